// File: exec_unit_defines.svh
// constants for the bit-and / compare-jump execution unit
// assumes inclusion by bit_and_compare_branch_exec.sv only; exec_unit_pkg.sv does not include it
`ifndef EXEC_UNIT_DEFINES_SVH
`define EXEC_UNIT_DEFINES_SVH

`define OPC_AND_DIR_IMM  8'h53
`define OPC_AND_C_BIT    8'h82
`define OPC_AND_C_NBIT   8'hB0
`define OPC_CJ_A_DIR     8'hB5
`define OPC_CJ_A_IMM     8'hB4
`define OPC_CJ_IND_HI    7'h5B
`define OPC_CJ_REG_HI    5'h17

`define LEN_THREE        16'h0003
`define LEN_TWO          16'h0002
`define MC_PER_INSTR     2
`define CLK_PER_MC       12

`define SFR_ACC          8'hE0
`define SFR_PSW          8'hD0
`define SFR_PORT_ONE     8'h90
`define SFR_SPACE_BIT    7
`define PSW_CY           7
`define PSW_BANK_HI      4
`define PSW_BANK_LO      3
`define BIT_AREA_HI      4'h2
`define RAM_DEPTH        128

`define ACC_RST          8'h00
`define PSW_RST          8'h00
`define PORT_ONE_RST     8'hFF
`define RAM_RST          8'h00

`endif

// File: exec_unit_pkg.sv
// types for the bit-and / compare-jump execution unit
// assumes no macros; exec_unit_defines.svh is not included here
package exec_unit_pkg;
  typedef enum logic [2:0] {
    OP_NONE    = 3'b000,
    OP_AND_DIR = 3'b001,
    OP_AND_C   = 3'b010,
    OP_AND_NC  = 3'b011,
    OP_CJ_DIR  = 3'b100,
    OP_CJ_IMM  = 3'b101,
    OP_CJ_IND  = 3'b110,
    OP_CJ_REG  = 3'b111
  } op_kind_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } exec_state_t;
endpackage : exec_unit_pkg

// File: bit_and_compare_branch_exec.sv
// execution unit for byte and-immediate, carry bit-and and compare-jump-not-equal
// assumes the fetch path hands over a whole instruction at once and waits for done
`timescale 1ns/100ps
`include "exec_unit_defines.svh"

// Notes on behaviour
// - and direct,#imm: 3 bytes, 2 machine cycles, result written back to direct byte
// - carry bit-and clears carry when source bit is zero, else keeps it
// - complemented form uses inverted bit; the stored bit stays untouched
// - carry bit-and changes no flag other than carry
// - carry bit-and source comes only from a direct bit address
// - opcode 82h plus bit address: 2 bytes, 2 machine cycles
// - opcode B0h plus bit address: 2 bytes, 2 machine cycles
// - compare-jump branches only when the two compared values differ
// - target is pc past the instruction plus signed last byte
// - compare-jump sets carry when first operand is unsigned-less, else clears it
// - compare-jump writes only pc and carry, never its operands
// - compare-jump pairings: acc/direct, acc/imm, indirect/imm, register/imm
// - opcode B5h, direct byte, displacement: 3 bytes, 2 machine cycles
// - opcode B4h, immediate byte, displacement: 3 bytes
// - opcodes B6h/B7h, low bit picks pointer register, immediate, displacement
module bit_and_compare_branch_exec
  import exec_unit_pkg::*;
#(
  parameter int CLK_PER_MC = `CLK_PER_MC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        instr_valid,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  operand_a,
  input  wire logic [7:0]  operand_b,
  input  wire logic [15:0] instr_pc,
  input  wire logic        load_en,
  input  wire logic [7:0]  load_addr,
  input  wire logic [7:0]  load_data,
  input  wire logic [7:0]  port_one_pins,
  output logic             busy_q,
  output logic             done_q,
  output logic             illegal_q,
  output logic [15:0]      next_pc_q,
  output logic [7:0]       accumulator_register_q,
  output logic [7:0]       status_word_q,
  output logic [7:0]       port_one_latch_q
);
  import exec_unit_pkg::*;

  localparam int EXEC_CLKS = `MC_PER_INSTR * CLK_PER_MC;
  localparam logic [7:0] LAST_CNT = 8'(EXEC_CLKS - 1);

  exec_state_t state_q;
  op_kind_t    kind_q;
  logic [7:0]  op_q;
  logic [7:0]  arg_a_q;
  logic [7:0]  arg_b_q;
  logic [15:0] pc_q;
  logic [7:0]  cnt_q;
  logic [7:0]  pins_meta_q;
  logic [7:0]  pins_q;
  logic [7:0]  ram_q [`RAM_DEPTH];

  // direct space: low half is data ram, upper half sfrs; port one reads pins
  // every source comes in as an argument so continuous callers re-evaluate on it
  function automatic logic [7:0] direct_read(
    input logic [7:0] a,
    input logic [7:0] ram_word,
    input logic [7:0] acc,
    input logic [7:0] psw,
    input logic [7:0] pins
  );
    logic [7:0] v;
    v = 8'h00;
    if (!a[`SFR_SPACE_BIT]) begin
      v = ram_word;
    end else if (a == `SFR_ACC) begin
      v = acc;
    end else if (a == `SFR_PSW) begin
      v = psw;
    end else if (a == `SFR_PORT_ONE) begin
      v = pins;
    end
    return v;
  endfunction : direct_read

  // bit address to the byte that holds it
  function automatic logic [7:0] bit_byte_addr(input logic [7:0] b);
    logic [7:0] r;
    r = b[`SFR_SPACE_BIT] ? {b[7:3], 3'b000} : {`BIT_AREA_HI, b[6:3]};
    return r;
  endfunction : bit_byte_addr

  function automatic op_kind_t decode_kind(input logic [7:0] o);
    op_kind_t k;
    k = OP_NONE;
    if (o == `OPC_AND_DIR_IMM) k = OP_AND_DIR;
    else if (o == `OPC_AND_C_BIT) k = OP_AND_C;
    else if (o == `OPC_AND_C_NBIT) k = OP_AND_NC;
    else if (o == `OPC_CJ_A_DIR) k = OP_CJ_DIR;
    else if (o == `OPC_CJ_A_IMM) k = OP_CJ_IMM;
    else if (o[7:1] == `OPC_CJ_IND_HI) k = OP_CJ_IND;
    else if (o[7:3] == `OPC_CJ_REG_HI) k = OP_CJ_REG;
    return k;
  endfunction : decode_kind

  wire op_kind_t   new_kind  = decode_kind(opcode);
  wire logic       start     = (state_q == ST_IDLE) && instr_valid;
  wire logic       finish    = (state_q == ST_EXEC) && (cnt_q == LAST_CNT);
  wire logic       carry     = status_word_q[`PSW_CY];

  // operand fetch
  wire logic [7:0] bank_base = {3'b000, status_word_q[`PSW_BANK_HI:`PSW_BANK_LO], 3'b000};
  wire logic [7:0] rn_addr   = bank_base | {5'b00000, op_q[2:0]};
  wire logic [7:0] ri_addr   = bank_base | {7'b0000000, op_q[0]};
  wire logic [7:0] rn_val    = ram_q[rn_addr[6:0]];
  wire logic [7:0] ri_ptr    = ram_q[ri_addr[6:0]];
  wire logic [7:0] ind_val   = ram_q[ri_ptr[6:0]];
  wire logic [7:0] dir_val   = direct_read(arg_a_q, ram_q[arg_a_q[6:0]],
                                           accumulator_register_q, status_word_q, pins_q);
  // only direct bit addressing exists for the carry-and source
  wire logic [7:0] bit_addr  = bit_byte_addr(arg_a_q);
  wire logic [7:0] bit_byte  = direct_read(bit_addr, ram_q[bit_addr[6:0]],
                                           accumulator_register_q, status_word_q, pins_q);
  wire logic       bit_raw   = bit_byte[arg_a_q[2:0]];
  // inversion happens on the read path only, nothing is written back
  wire logic       bit_src   = (kind_q == OP_AND_NC) ? ~bit_raw : bit_raw;
  wire logic       carry_and = carry & bit_src;

  // compare-jump
  wire logic       cj_acc    = (kind_q == OP_CJ_DIR) || (kind_q == OP_CJ_IMM);
  wire logic [7:0] cmp_lhs   = cj_acc ? accumulator_register_q :
                               (kind_q == OP_CJ_IND) ? ind_val : rn_val;
  wire logic [7:0] cmp_rhs   = (kind_q == OP_CJ_DIR) ? dir_val : arg_a_q;
  wire logic       not_equal = cmp_lhs != cmp_rhs;
  wire logic       less      = cmp_lhs < cmp_rhs;
  wire logic       is_cj     = kind_q[2];
  wire logic [15:0] pc_past3 = pc_q + `LEN_THREE;
  wire logic [15:0] pc_past2 = pc_q + `LEN_TWO;
  wire logic [15:0] target   = pc_past3 + {{8{arg_b_q[7]}}, arg_b_q};
  wire logic [15:0] pc_new   = (kind_q == OP_AND_C || kind_q == OP_AND_NC) ? pc_past2 :
                               (is_cj && not_equal) ? target : pc_past3;

  // and direct,#imm: port one modifies its latch, not the pins
  wire logic        is_and_dir = kind_q == OP_AND_DIR;
  wire logic [7:0]  rmw_src  = (arg_a_q == `SFR_PORT_ONE) ? port_one_latch_q : dir_val;
  wire logic [7:0]  and_res  = rmw_src & arg_b_q;

  // a single write path: load port while idle, result at the end of execution
  wire logic        wr_exec  = finish && is_and_dir;
  wire logic        wr_en    = wr_exec || ((state_q == ST_IDLE) && load_en && !instr_valid);
  wire logic [7:0]  wr_addr  = wr_exec ? arg_a_q : load_addr;
  wire logic [7:0]  wr_data  = wr_exec ? and_res : load_data;
  wire logic        wr_ram   = wr_en && !wr_addr[`SFR_SPACE_BIT];
  wire logic        carry_wr = finish && (kind_q != OP_AND_DIR) && (kind_q != OP_NONE);
  // other flags keep their value, only the carry position is replaced
  wire logic        carry_nx = is_cj ? less : carry_and;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_meta_q <= `PORT_ONE_RST;
      pins_q      <= `PORT_ONE_RST;
    end else begin
      pins_meta_q <= port_one_pins;
      pins_q      <= pins_meta_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q   <= 8'h00;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          cnt_q <= 8'h00;
          if (instr_valid && new_kind != OP_NONE) begin
            state_q <= ST_EXEC;
          end
        end
        // every instruction here spans two machine cycles
        ST_EXEC: begin
          cnt_q <= cnt_q + 8'h01;
          if (finish) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      kind_q  <= OP_NONE;
      op_q    <= 8'h00;
      arg_a_q <= 8'h00;
      arg_b_q <= 8'h00;
      pc_q    <= 16'h0000;
    end else if (start) begin
      kind_q  <= new_kind;
      op_q    <= opcode;
      arg_a_q <= operand_a;
      arg_b_q <= operand_b;
      pc_q    <= instr_pc;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
      illegal_q <= 1'b0;
      next_pc_q <= 16'h0000;
    end else begin
      busy_q    <= (start && new_kind != OP_NONE) || (busy_q && !finish);
      done_q    <= finish;
      illegal_q <= start && (new_kind == OP_NONE);
      if (finish) begin
        next_pc_q <= pc_new;
      end
    end
  end

  // compare-jump never reaches this path, so its operands stay intact
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      accumulator_register_q <= `ACC_RST;
      port_one_latch_q       <= `PORT_ONE_RST;
    end else if (wr_en) begin
      if (wr_addr == `SFR_ACC) accumulator_register_q <= wr_data;
      if (wr_addr == `SFR_PORT_ONE) port_one_latch_q <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_word_q <= `PSW_RST;
    end else if (wr_en && wr_addr == `SFR_PSW) begin
      status_word_q <= wr_data;
    end else if (carry_wr) begin
      status_word_q[`PSW_CY] <= carry_nx;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `RAM_DEPTH; i++) begin
        ram_q[i] <= `RAM_RST;
      end
    end else if (wr_ram) begin
      ram_q[wr_addr[6:0]] <= wr_data;
    end
  end
endmodule : bit_and_compare_branch_exec

// File: exec_unit_monitor.sv
// assertion checker for the bit-and / compare-jump execution unit
// assumes it is bound to bit_and_compare_branch_exec and sees only its ports
`timescale 1ns/100ps
module exec_unit_monitor #(
  parameter int CLK_PER_MC = 12
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        instr_valid,
  input wire logic [7:0]  opcode,
  input wire logic [7:0]  operand_a,
  input wire logic [7:0]  operand_b,
  input wire logic [15:0] instr_pc,
  input wire logic        busy_q,
  input wire logic        done_q,
  input wire logic        illegal_q,
  input wire logic [15:0] next_pc_q,
  input wire logic [7:0]  accumulator_register_q,
  input wire logic [7:0]  status_word_q
);
  logic [7:0]  op_s, a_s, b_s, acc_s, psw_s, cnt_q;
  logic [15:0] pc_s;
  wire take  = instr_valid && !busy_q;
  wire legal = opcode == 8'h53 || opcode == 8'h82 || opcode == 8'hB0
               || (opcode[7:4] == 4'hB && opcode[3:0] >= 4'h4);
  wire and_c = op_s == 8'h82 || op_s == 8'hB0;
  wire [15:0] disp = (acc_s != a_s) ? {{8{b_s[7]}}, b_s} : 16'h0000;
  // operands frozen at the take edge, since the ports may move while busy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {op_s, a_s, b_s, acc_s, psw_s, pc_s} <= '0;
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= take ? 8'h00 : (cnt_q == 8'hFF ? cnt_q : cnt_q + 8'h01);
      if (take) {op_s, a_s, b_s, acc_s, psw_s, pc_s} <=
          {opcode, operand_a, operand_b, accumulator_register_q, status_word_q, instr_pc};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  done_timing_a: assert property (done_q |-> cnt_q == 8'(2 * CLK_PER_MC))
    else $error("done at wrong distance from take");
  illegal_flag_a: assert property (take && !legal |=> illegal_q && !busy_q)
    else $error("unknown opcode not flagged");
  done_pulse_a: assert property (done_q |=> !done_q && !busy_q)
    else $error("done longer than one cycle");
  cj_carry_a: assert property (
    done_q && op_s == 8'hB4 |-> status_word_q[7] == (acc_s < a_s))
    else $error("compare carry wrong");
  cj_target_a: assert property (
    done_q && op_s == 8'hB4 |-> next_pc_q == pc_s + 16'h0003 + disp)
    else $error("branch target wrong");
  bit_len_a: assert property (done_q && and_c |-> next_pc_q == pc_s + 16'h0002)
    else $error("bit-and length wrong");
  flags_kept_a: assert property (
    done_q && and_c |-> status_word_q[6:0] == psw_s[6:0])
    else $error("bit-and touched other flags");
  carry_stays_a: assert property (
    done_q && and_c && !psw_s[7] |-> !status_word_q[7])
    else $error("bit-and set carry");
  acc_kept_a: assert property (
    done_q && op_s >= 8'hB4 |-> accumulator_register_q == acc_s)
    else $error("compare changed accumulator");
  and_len_a: assert property (
    done_q && op_s == 8'h53 |-> next_pc_q == pc_s + 16'h0003)
    else $error("byte-and length wrong");
endmodule : exec_unit_monitor

// File: bit_and_compare_branch_exec_bench.sv
// self-checking bench for the bit-and / compare-jump execution unit
// assumes exec_unit_pkg and exec_unit_monitor are compiled before this file
`timescale 1ns/100ps
module bit_and_compare_branch_exec_bench;
  typedef struct {logic [15:0] pc; logic [7:0] psw, acc, lat;} exp_t;
  logic        clk = 0, rst_n = 0, instr_valid = 0, load_en = 0;
  logic [7:0]  opcode = 0, operand_a = 0, operand_b = 0, load_addr = 0, load_data = 0;
  logic [7:0]  port_one_pins = 8'hA5, acc = 8'h00, psw = 8'h00, lat = 8'hFF;
  logic [15:0] instr_pc = 0, next_pc_q;
  logic        busy_q, done_q, illegal_q;
  logic [7:0]  accumulator_register_q, status_word_q, port_one_latch_q;
  logic [7:0]  ram [128];
  logic [7:0]  ops [8] = '{8'h53, 8'h82, 8'hB0, 8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hB8};
  logic [7:0]  sel [5] = '{8'h90, 8'h97, 8'hE7, 8'h00, 8'h90};
  exp_t        q[$];
  exp_t        e;
  int          err_total = 0, checks = 0;
  bit_and_compare_branch_exec #(.CLK_PER_MC(1)) i_dut (
    .clk                    (clk),
    .rst_n                  (rst_n),
    .instr_valid            (instr_valid),
    .opcode                 (opcode),
    .operand_a              (operand_a),
    .operand_b              (operand_b),
    .instr_pc               (instr_pc),
    .load_en                (load_en),
    .load_addr              (load_addr),
    .load_data              (load_data),
    .port_one_pins          (port_one_pins),
    .busy_q                 (busy_q),
    .done_q                 (done_q),
    .illegal_q              (illegal_q),
    .next_pc_q              (next_pc_q),
    .accumulator_register_q (accumulator_register_q),
    .status_word_q          (status_word_q),
    .port_one_latch_q       (port_one_latch_q)
  );
  initial forever #2 clk = ~clk;
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task print_verdict;
    if (err_total == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // port one reads the pins, except the and-direct rmw which uses the latch
  function automatic logic [7:0] rd(input logic [7:0] a);
    return a < 8'h80 ? ram[a[6:0]] : a == 8'hE0 ? acc : a == 8'hD0 ? psw
           : a == 8'h90 ? port_one_pins : 8'h00;
  endfunction : rd
  function automatic void wr(input logic [7:0] a, input logic [7:0] d);
    if (a < 8'h80) ram[a[6:0]] = d;
    else if (a == 8'hE0) acc = d;
    else if (a == 8'hD0) psw = d;
    else if (a == 8'h90) lat = d;
  endfunction : wr
  task ld(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    load_en <= 1'b1;
    load_addr <= a;
    load_data <= d;
    @(posedge clk);
    load_en <= 1'b0;
    wr(a, d);
  endtask : ld
  task issue(input logic [7:0] op, a, b, input logic [15:0] pc);
    @(posedge clk);
    instr_valid <= 1'b1;
    opcode <= op;
    operand_a <= a;
    operand_b <= b;
    instr_pc <= pc;
    @(posedge clk);
    instr_valid <= 1'b0;
  endtask : issue
  task run(input logic [7:0] op, a, b);
    logic [7:0]  x, y, v;
    logic [15:0] pc, np;
    logic        c;
    int          n;
    pc = 16'($urandom);
    c = psw[7];
    x = op[3] ? ram[{2'b00, psw[4:3], op[2:0]}]
      : op[1] ? ram[ram[{2'b00, psw[4:3], 2'b00, op[0]}][6:0]] : acc;
    y = op == 8'hB5 ? rd(a) : a;
    v = rd(a[7] ? {a[7:3], 3'b000} : 8'h20 + 8'(a[6:3]));
    np = pc + ((op == 8'h82 || op == 8'hB0) ? 16'h0002 : 16'h0003);
    if (op >= 8'hB4 && x != y) np = np + {{8{b[7]}}, b};
    if (op >= 8'hB4) c = x < y;
    if (op == 8'h82) c = c & v[a[2:0]];
    if (op == 8'hB0) c = c & ~v[a[2:0]];
    if (op == 8'h53) wr(a, (a == 8'h90 ? lat : rd(a)) & b);
    else psw[7] = c;
    q.push_back('{np, psw, acc, lat});
    issue(op, a, b, pc);
    for (n = 0; n < 40 && done_q !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
  endtask : run
  always @(posedge clk) begin
    if (done_q === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      chk(next_pc_q, e.pc);
      chk({8'h00, status_word_q}, {8'h00, e.psw});
      chk({accumulator_register_q, port_one_latch_q}, {e.acc, e.lat});
    end
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    print_verdict();
  end
  initial begin
    int         i;
    logic [7:0] op, a;
    void'($urandom(32'h55B1));
    for (i = 0; i < 128; i++) ram[i] = 8'h00;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    port_one_pins <= 8'($urandom);
    for (i = 0; i < 128; i++) ld(8'(i), 8'($urandom));
    ld(8'hE0, 8'($urandom));
    ld(8'hD0, 8'($urandom));
    ld(8'h90, 8'($urandom));
    for (i = 0; i < 240; i++) begin
      op = ops[i % 8] + ((i % 8 == 7) ? 8'($urandom % 8) : 8'h00);
      a = (i % 16 == 3) ? acc : (i % 16 < 5) ? sel[i % 16] : 8'($urandom);
      run(op, a, 8'($urandom));
    end
    issue(8'hA5, 8'h00, 8'h00, 16'h0000);
    #1 chk(16'(illegal_q), 16'h0001);
    chk(16'(q.size()), 16'h0000);
    print_verdict();
  end
endmodule : bit_and_compare_branch_exec_bench
bind bit_and_compare_branch_exec exec_unit_monitor #(.CLK_PER_MC(CLK_PER_MC)) i_mon (
  .clk                    (clk),
  .rst_n                  (rst_n),
  .instr_valid            (instr_valid),
  .opcode                 (opcode),
  .operand_a              (operand_a),
  .operand_b              (operand_b),
  .instr_pc               (instr_pc),
  .busy_q                 (busy_q),
  .done_q                 (done_q),
  .illegal_q              (illegal_q),
  .next_pc_q              (next_pc_q),
  .accumulator_register_q (accumulator_register_q),
  .status_word_q          (status_word_q)
);
